// >>> design/fbrm_mem.sv
// Purpose: holding register table, one port, registered read data
// Assumes: write and read share the address; read data valid one cycle later
// Notes:   contents are not reset
`timescale 1ns/10ps
module fbrm_mem #(
  parameter int W  = 16,
  parameter int AW = 8
) (
  // Clock
  input  wire logic          clock,
  // Access port
  input  wire logic [AW-1:0] addr,
  input  wire logic          wr,
  input  wire logic [W-1:0]  wdata,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem_r [0:(1<<AW)-1];

  // Write then registered read
  always_ff @(posedge clock) begin
    if (wr) begin
      mem_r[addr] <= wdata;
    end
    rdata <= mem_r[addr];
  end
endmodule // fbrm_mem

// >>> design/fbrm_rev.sv
// Purpose: optional bit order reversal of one word
// Assumes: purely combinational
// Notes:   passes data through when en is low
`timescale 1ns/10ps
module fbrm_rev #(
  parameter int W = 16
) (
  // Data
  input  wire logic [W-1:0] din,
  input  wire logic         en,
  output logic      [W-1:0] dout
);
  // Mirror bit i to bit W-1-i
  always_comb begin
    for (int i = 0; i < W; i++) begin
      dout[i] = en ? din[W-1-i] : din[i];
    end
  end
endmodule // fbrm_rev

// >>> design/fbrm_top.sv
// Purpose: maps fieldbus holding registers onto rack card words and mapper copies
// Assumes: fieldbus requests arrive decoded; backplane port answers with bp_ack
// Notes:   one timeout timer restarted by every accepted master message
`timescale 1ns/10ps
module fbrm_top
  import fbrm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // Avalon-MM register slave
  input  wire logic [7:0]    av_address,
  input  wire logic          av_read,
  input  wire logic          av_write,
  input  wire logic [31:0]   av_writedata,
  output logic      [31:0]   av_readdata,
  output logic               av_waitrequest,
  // Decoded fieldbus requests
  input  wire fbrm_fb_req_t  fb_req,
  output logic               fb_ready,
  output fbrm_fb_rsp_t       fb_rsp,
  // Rack backplane
  output fbrm_bp_req_t       bp_req,
  input  wire logic          bp_ack,
  input  wire logic [15:0]   bp_rdata,
  // Serial port setup and status
  output fbrm_ser_cfg_t      ser_cfg,
  output logic               dual_slave,
  output logic               timed_out
);
  typedef struct packed {
    fbrm_state_t         st;
    logic [31:0]         ctrl;
    logic [31:0]         tmo;
    logic [31:0]         ser;
    logic [3:0][31:0]    rack;
    logic [3:0][31:0]    rdef;
    logic [1:0][31:0]    map;
    logic [1:0][31:0]    mctl;
    logic [15:0]         errcnt;
    logic [2:0]          ent;
    logic [7:0]          wrd;
    logic [31:0]         tick;
    logic [15:0]         ms;
    logic                timed_out;
    logic                av_ack;
    logic [31:0]         av_rdata;
    fbrm_fb_rsp_t        rsp;
    fbrm_bp_req_t        bp;
    logic [15:0]         hold;
  } fbrm_regs_t;

  fbrm_regs_t     r_r;
  fbrm_regs_t     r_nxt;
  fbrm_rack_ent_t rk;
  fbrm_map_ent_t  mp;
  fbrm_map_ctl_t  mc;
  fbrm_map_ent_t  mpj;
  fbrm_map_ctl_t  mcj;
  logic [7:0]     rk_reg;
  logic           cov;
  logic [15:0]    cov_dflt;
  logic [15:0]    rdef_cur;
  logic [7:0]     cur_cnt;
  logic           last_wrd;
  logic [2:0]     adv_ent;
  logic [31:0]    cfg_av;
  logic [31:0]    cfg_fb;
  logic [31:0]    cfg_int;
  logic           fb_take;
  logic           proto_ok;
  logic [7:0]     mem_addr;
  logic           mem_wr;
  logic [15:0]    mem_wdata;
  logic [15:0]    mem_rdata;
  logic [15:0]    rev_out;

  // Config word read by word index
  function automatic logic [31:0] cfg_read(input fbrm_regs_t s, input logic [5:0] idx);
    logic [7:0] a;
    a = {idx, 2'b00};
    cfg_read = 32'h00000000;
    if (a == OFF_CTRL) cfg_read = s.ctrl;
    else if (a == OFF_TMO) cfg_read = s.tmo;
    else if (a == OFF_SER) cfg_read = s.ser;
    else if (a == OFF_STAT) cfg_read = {30'h0, s.st != S_IDLE, s.timed_out};
    else if (a == OFF_ERR) cfg_read = {16'h0, s.errcnt};
    else if (a >= OFF_RACK && a < OFF_RDEF) cfg_read = s.rack[a[3:2]];
    else if (a >= OFF_RDEF && a < OFF_MAP) cfg_read = s.rdef[a[3:2]];
    else if (a >= OFF_MAP && a < OFF_MCTL) cfg_read = s.map[a[2]];
    else if (a >= OFF_MCTL && a < OFF_END) cfg_read = s.mctl[a[2]];
  endfunction

  // Config word write; read-only and unmapped words ignore it
  function automatic fbrm_regs_t cfg_write(input fbrm_regs_t s, input logic [5:0] idx,
                                           input logic [31:0] d);
    logic [7:0] a;
    a = {idx, 2'b00};
    cfg_write = s;
    if (a == OFF_CTRL) cfg_write.ctrl = d;
    else if (a == OFF_TMO) cfg_write.tmo = d;
    else if (a == OFF_SER) cfg_write.ser = d;
    else if (a >= OFF_RACK && a < OFF_RDEF) cfg_write.rack[a[3:2]] = d;
    else if (a >= OFF_RDEF && a < OFF_MAP) cfg_write.rdef[a[3:2]] = d;
    else if (a >= OFF_MAP && a < OFF_MCTL) cfg_write.map[a[2]] = d;
    else if (a >= OFF_MCTL && a < OFF_END) cfg_write.mctl[a[2]] = d;
  endfunction

  // Holding register table and bit reverser
  fbrm_mem #(.W(16), .AW(8)) u_mem (
    .clock (clock),
    .addr  (mem_addr),
    .wr    (mem_wr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  fbrm_rev #(.W(16)) u_rev (
    .din  (r_r.hold),
    .en   (mc.rev),
    .dout (rev_out)
  );

  // Current entry view, default coverage and step bookkeeping
  always_comb begin
    rk       = fbrm_rack_ent_t'(r_r.rack[r_r.ent[1:0]]);
    mp       = fbrm_map_ent_t'(r_r.map[r_r.ent[0]]);
    mc       = fbrm_map_ctl_t'(r_r.mctl[r_r.ent[0]]);
    rdef_cur = r_r.rdef[r_r.ent[1:0]][15:0];
    rk_reg   = 8'(rk.start + r_r.wrd);
    cov      = 1'b0;
    cov_dflt = 16'h0000;
    mpj      = fbrm_map_ent_t'(r_r.map[0]);
    mcj      = fbrm_map_ctl_t'(r_r.mctl[0]);
    for (int j = 0; j < N_MAP; j++) begin
      mpj = fbrm_map_ent_t'(r_r.map[j]);
      mcj = fbrm_map_ctl_t'(r_r.mctl[j]);
      if (mcj.out && mpj.sel == SRC_RACK && rk_reg >= mpj.src &&
          {1'b0, rk_reg} < 9'(mpj.src) + 9'(mpj.count)) begin
        cov      = 1'b1;
        cov_dflt = mcj.dflt;
      end
    end
    cur_cnt  = (r_r.ent < 3'(N_RACK)) ? rk.count : mp.count;
    last_wrd = (9'(r_r.wrd) + 9'h001) >= 9'(cur_cnt);
    adv_ent  = (r_r.ent == 3'(N_ENT - 1)) ? 3'h0 : 3'(r_r.ent + 3'h1);
    cfg_av   = cfg_read(r_r, av_address[7:2]);
    cfg_fb   = cfg_read(r_r, fb_req.regno[5:0]);
    cfg_int  = cfg_read(r_r, 6'(mp.src + r_r.wrd));
    fb_ready = (r_r.st == S_IDLE) && !av_write;
    fb_take  = fb_req.valid && fb_ready;
    proto_ok = (fb_req.proto == PROTO_MODBUS) || r_r.ctrl[CTRL_DUAL];
  end

  // Next state of the whole block
  always_comb begin
    r_nxt       = r_r;
    mem_addr    = r_r.bp.word;
    mem_wr      = 1'b0;
    mem_wdata   = bp_rdata;
    r_nxt.rsp.valid = 1'b0;
    r_nxt.av_ack    = 1'b0;
    // Millisecond timer and timeout flag
    if (r_r.tick >= 32'(MS_CYCLES - 1)) begin
      r_nxt.tick = 32'h0;
      if (!r_r.timed_out) r_nxt.ms = 16'(r_r.ms + 16'h1);
    end else begin
      r_nxt.tick = 32'(r_r.tick + 32'h1);
    end
    if (r_r.tmo[15:0] != 16'h0 && r_r.ms >= r_r.tmo[15:0]) r_nxt.timed_out = 1'b1;
    // Avalon slave: one wait cycle, write lands on the released edge
    if ((av_read || av_write) && !r_r.av_ack) begin
      r_nxt.av_ack   = 1'b1;
      r_nxt.av_rdata = cfg_av;
    end
    if (r_r.av_ack && av_write) r_nxt = cfg_write(r_nxt, av_address[7:2], av_writedata);
    case (r_r.st)
      S_IDLE: begin
        if (fb_take) begin
          if (!proto_ok || !(fb_req.slave == SLV_CFG || fb_req.slave == SLV_RACK_A ||
                             fb_req.slave == SLV_RACK_B)) begin
            r_nxt.rsp    = '{valid: 1'b1, err: 1'b1, rdata: 16'h0000};
            r_nxt.errcnt = 16'(r_r.errcnt + 16'h1);
          end else begin
            r_nxt.ms        = 16'h0;
            r_nxt.tick      = 32'h0;
            r_nxt.timed_out = 1'b0;
            if (fb_req.slave == SLV_CFG) begin
              r_nxt.rsp = '{valid: 1'b1, err: 1'b0, rdata: cfg_fb[15:0]};
              if (fb_req.write) begin
                r_nxt = cfg_write(r_nxt, fb_req.regno[5:0], {cfg_fb[31:16], fb_req.wdata});
                r_nxt.rsp.rdata = fb_req.wdata;
              end
            end else begin
              mem_addr  = fb_req.regno;
              mem_wr    = fb_req.write;
              mem_wdata = fb_req.wdata;
              if (fb_req.write) r_nxt.rsp = '{valid: 1'b1, err: 1'b0, rdata: fb_req.wdata};
              else r_nxt.st = S_FB_RD;
            end
          end
        end else if (r_r.ctrl[CTRL_SCAN]) begin
          if (cur_cnt == 8'h00 ||
              (r_r.ent >= 3'(N_RACK) && mc.out && (r_r.timed_out || mp.sel != SRC_RACK))) begin
            r_nxt.ent = adv_ent;
            r_nxt.wrd = 8'h00;
          end else if (r_r.ent < 3'(N_RACK)) begin
            mem_addr = rk_reg;
            if (rk.out) begin
              r_nxt.st = S_RK_RD;
            end else begin
              r_nxt.bp = '{valid: 1'b1, write: 1'b0, slot: rk.slot,
                           word: 8'(rk.sword + r_r.wrd), wdata: 16'h0000};
              r_nxt.st = S_RK_BP;
            end
          end else if (mc.out) begin
            mem_addr = 8'(mp.target + r_r.wrd);
            r_nxt.st = S_MP_RD;
          end else if (mp.sel == SRC_INT) begin
            r_nxt.hold = cfg_int[15:0];
            r_nxt.st   = S_MP_WR;
          end else begin
            mem_addr = 8'(mp.src + r_r.wrd);
            r_nxt.st = S_MP_RD;
          end
        end
      end
      S_FB_RD: begin
        r_nxt.rsp = '{valid: 1'b1, err: 1'b0, rdata: mem_rdata};
        r_nxt.st  = S_IDLE;
      end
      S_RK_RD: begin
        r_nxt.bp = '{valid: 1'b1, write: 1'b1, slot: rk.slot,
                     word: 8'(rk.sword + r_r.wrd), wdata: mem_rdata};
        if (r_r.timed_out) r_nxt.bp.wdata = cov ? cov_dflt : rdef_cur;
        r_nxt.st = S_RK_BP;
      end
      S_RK_BP: begin
        if (bp_ack) begin
          r_nxt.bp.valid = 1'b0;
          mem_addr       = rk_reg;
          mem_wr         = !r_r.bp.write;
          mem_wdata      = bp_rdata;
          r_nxt.ent      = last_wrd ? adv_ent : r_nxt.ent;
          r_nxt.wrd      = last_wrd ? 8'h00 : 8'(r_r.wrd + 8'h01);
          r_nxt.st       = S_IDLE;
        end
      end
      S_MP_RD: begin
        r_nxt.hold = mem_rdata;
        r_nxt.st   = S_MP_WR;
      end
      S_MP_WR: begin
        mem_addr  = mc.out ? 8'(mp.src + r_r.wrd) : 8'(mp.target + r_r.wrd);
        mem_wr    = 1'b1;
        mem_wdata = rev_out;
        r_nxt.ent = last_wrd ? adv_ent : r_nxt.ent;
        r_nxt.wrd = last_wrd ? 8'h00 : 8'(r_r.wrd + 8'h01);
        r_nxt.st  = S_IDLE;
      end
      default: r_nxt.st = S_IDLE;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clock) begin
    if (reset) begin
      r_r      <= '0;
      r_r.st   <= S_IDLE;
      r_r.ctrl <= CTRL_RST;
      r_r.tmo  <= TMO_RST;
      r_r.ser  <= SER_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs
  assign av_readdata    = r_r.av_rdata;
  assign av_waitrequest = (av_read || av_write) && !r_r.av_ack;
  assign fb_rsp         = r_r.rsp;
  assign bp_req         = r_r.bp;
  assign ser_cfg        = fbrm_ser_cfg_t'(r_r.ser);
  assign dual_slave     = r_r.ctrl[CTRL_DUAL];
  assign timed_out      = r_r.timed_out;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_bp_start;
    r_r.st == S_RK_BP && r_r.bp.valid;
  endsequence
  sequence s_bp_wait;
    r_r.bp.valid && !bp_ack;
  endsequence

  property p_slot_addr;
    s_bp_start |-> r_r.bp.slot == rk.slot && r_r.bp.word == 8'(rk.sword + r_r.wrd);
  endproperty
  a_slot_addr: assert property (p_slot_addr) else $error("slot address mismatch");
  property p_bp_hold;
    s_bp_wait |=> r_r.bp.valid && $stable(r_r.bp.word) && $stable(r_r.bp.wdata);
  endproperty
  a_bp_hold: assert property (p_bp_hold) else $error("backplane request dropped");
  property p_tmo_default;
    r_r.st == S_RK_RD && r_r.timed_out && !cov |=> r_r.bp.wdata == $past(rdef_cur);
  endproperty
  a_tmo_default: assert property (p_tmo_default) else $error("default not sent");
  property p_map_prec;
    r_r.st == S_RK_RD && r_r.timed_out && cov |=> r_r.bp.wdata == $past(cov_dflt);
  endproperty
  a_map_prec: assert property (p_map_prec) else $error("mapper default lost");
  property p_rev;
    r_r.st == S_MP_WR && mc.rev |-> mem_wdata[0] == r_r.hold[15] && mem_wdata[15] == r_r.hold[0];
  endproperty
  a_rev: assert property (p_rev) else $error("bit order not reversed");
  property p_map_target;
    r_r.st == S_MP_WR && !mc.out |-> mem_wr && mem_addr == 8'(mp.target + r_r.wrd);
  endproperty
  a_map_target: assert property (p_map_target) else $error("mapper target wrong");
  property p_ser_reset;
    $past(reset) |-> r_r.ser == SER_RST;
  endproperty
  a_ser_reset: assert property (p_ser_reset) else $error("serial default wrong");
  property p_bad_slave;
    fb_take && fb_req.slave != SLV_CFG && fb_req.slave > SLV_RACK_B |=> fb_rsp.valid && fb_rsp.err;
  endproperty
  a_bad_slave: assert property (p_bad_slave) else $error("foreign slave answered");
  property p_dual;
    fb_take && r_r.ctrl[CTRL_DUAL] && fb_req.slave == SLV_CFG |=> fb_rsp.valid && !fb_rsp.err;
  endproperty
  a_dual: assert property (p_dual) else $error("dual slave refused");
  property p_restart;
    fb_take && proto_ok && fb_req.slave == SLV_RACK_B |=> !r_r.timed_out && r_r.ms == 16'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("timeout not restarted");
endmodule // fbrm_top

// >>> shared/fbrm_pkg.sv
// Purpose: shared constants and carrier types of the fieldbus rack register mapper
// Assumes: 40 MHz clock; register byte offsets below are word aligned
// Notes:   config words are 32 bits, fieldbus and rack words are 16 bits
package fbrm_pkg;
  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  // Table sizes
  localparam int N_RACK = 4;
  localparam int N_MAP  = 2;
  localparam int N_ENT  = N_RACK + N_MAP;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TMO  = 8'h04;
  localparam logic [7:0] OFF_SER  = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_ERR  = 8'h10;
  localparam logic [7:0] OFF_RACK = 8'h20;
  localparam logic [7:0] OFF_RDEF = 8'h30;
  localparam logic [7:0] OFF_MAP  = 8'h40;
  localparam logic [7:0] OFF_MCTL = 8'h48;
  localparam logic [7:0] OFF_END  = 8'h50;
  // Control fields and reset values
  localparam int          CTRL_DUAL = 0;
  localparam int          CTRL_SCAN = 1;
  localparam logic [31:0] CTRL_RST  = 32'h00000003;
  localparam logic [31:0] TMO_RST   = 32'h000003e8;
  // Serial framing defaults
  localparam logic [15:0] SER_BAUD     = 16'h2580;
  localparam logic [3:0]  SER_BITS     = 4'h8;
  localparam logic [1:0]  SER_PAR_EVEN = 2'h2;
  localparam logic [1:0]  SER_STOP     = 2'h1;
  localparam logic [31:0] SER_RST      = {8'h00, SER_STOP, SER_PAR_EVEN, SER_BITS, SER_BAUD};
  // Slave addresses and mapper sources
  localparam logic [7:0] SLV_CFG    = 8'hff;
  localparam logic [7:0] SLV_RACK_A = 8'h00;
  localparam logic [7:0] SLV_RACK_B = 8'h01;
  localparam logic [7:0] SRC_RACK   = 8'h00;
  localparam logic [7:0] SRC_INT    = 8'hff;
  localparam logic       PROTO_NATIVE = 1'b0;
  localparam logic       PROTO_MODBUS = 1'b1;

  typedef struct packed {
    logic [7:0]  rsv;
    logic [1:0]  stop;
    logic [1:0]  parity;
    logic [3:0]  bits;
    logic [15:0] baud;
  } fbrm_ser_cfg_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic       out;
    logic [7:0] count;
    logic [7:0] sword;
    logic [3:0] slot;
    logic [7:0] start;
  } fbrm_rack_ent_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] src;
    logic [7:0] sel;
    logic [7:0] target;
  } fbrm_map_ent_t;

  typedef struct packed {
    logic [13:0] rsv;
    logic        rev;
    logic        out;
    logic [15:0] dflt;
  } fbrm_map_ctl_t;

  typedef struct packed {
    logic        valid;
    logic        proto;
    logic [7:0]  slave;
    logic        write;
    logic [7:0]  regno;
    logic [15:0] wdata;
  } fbrm_fb_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] rdata;
  } fbrm_fb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  slot;
    logic [7:0]  word;
    logic [15:0] wdata;
  } fbrm_bp_req_t;

  typedef enum logic [2:0] {
    S_IDLE, S_FB_RD, S_RK_RD, S_RK_BP, S_MP_RD, S_MP_WR
  } fbrm_state_t;
endpackage

// >>> sim/fbrm_card.sv
// Purpose: behavioural rack cards behind the backplane port
// Assumes: one request at a time; acks promptly or after three wait cycles
// Notes:   card words start as {slot, word, 4'ha}; read data wanders while idle
`timescale 1ns/10ps
module fbrm_card
  import fbrm_pkg::*;
(
  // Clock, reset and pace
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         slow,
  // Backplane
  input  wire fbrm_bp_req_t bp_req,
  output logic              bp_ack,
  output logic      [15:0]  bp_rdata
);
  logic [15:0] mem [16][256];
  logic [1:0]  cnt;

  // Card contents encode their own position
  initial begin
    for (int s = 0; s < 16; s++) begin
      for (int w = 0; w < 256; w++) begin
        mem[s][w] = {s[3:0], w[7:0], 4'ha};
      end
    end
  end

  // Accept, store writes at the ack edge, scramble data when not answering
  always @(posedge clock) begin
    if (reset) begin
      bp_ack <= 1'h0;
      bp_rdata <= 16'h0000;
      cnt <= 2'h0;
    end else if (bp_ack) begin
      bp_ack <= 1'h0;
      cnt <= 2'h0;
      bp_rdata <= ~bp_rdata;
      if (bp_req.write) begin
        mem[bp_req.slot][bp_req.word] <= bp_req.wdata;
      end
    end else if (bp_req.valid && cnt >= (slow ? 2'h3 : 2'h0)) begin
      bp_ack <= 1'h1;
      bp_rdata <= mem[bp_req.slot][bp_req.word];
    end else begin
      cnt <= bp_req.valid ? cnt + 2'h1 : 2'h0;
      bp_rdata <= ~bp_rdata;
    end
  end
endmodule // fbrm_card

// >>> sim/tb.sv
// Purpose: self-checking bench of the rack register mapper
// Assumes: MS_CYCLES set to 4, so one timeout tick is four clocks
// Notes:   registers over Avalon-MM, master messages through fb_req
`timescale 1ns/10ps
module tb
  import fbrm_pkg::*;
;
  logic          clock = 1'h0;
  logic          reset = 1'h1;
  logic          slow = 1'h0;
  logic [7:0]    av_address = 8'h00;
  logic          av_read = 1'h0;
  logic          av_write = 1'h0;
  logic [31:0]   av_writedata = 32'h0;
  logic [31:0]   av_readdata;
  logic          av_waitrequest;
  fbrm_fb_req_t  fb_req = '0;
  logic          fb_ready;
  fbrm_fb_rsp_t  fb_rsp;
  fbrm_bp_req_t  bp_req;
  logic          bp_ack;
  logic [15:0]   bp_rdata;
  fbrm_ser_cfg_t ser_cfg;
  logic          dual_slave;
  logic          timed_out;
  logic [31:0]   rd;
  int            err_total = 0;
  int            total_checks = 0;

  always #12.5 clock = ~clock;

  fbrm_top #(.MS_CYCLES(4)) uut (.clock(clock), .reset(reset), .av_address(av_address),
    .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .fb_req(fb_req),
    .fb_ready(fb_ready), .fb_rsp(fb_rsp), .bp_req(bp_req), .bp_ack(bp_ack),
    .bp_rdata(bp_rdata), .ser_cfg(ser_cfg), .dual_slave(dual_slave), .timed_out(timed_out));

  fbrm_card card (.clock(clock), .reset(reset), .slow(slow), .bp_req(bp_req),
    .bp_ack(bp_ack), .bp_rdata(bp_rdata));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] rev16(input logic [15:0] d);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = d[15-i];
    end
  endfunction

  // One Avalon access, held until waitrequest is seen low
  task automatic av_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    av_address <= a;
    av_writedata <= d;
    av_write <= w;
    av_read <= ~w;
    // Hold until waitrequest is sampled low at a rising edge; take data there
    do begin
      @(posedge clock);
    end while (av_waitrequest !== 1'h0);
    rd = av_readdata;
    av_write <= 1'h0;
    av_read <= 1'h0;
  endtask

  // One master message; returns the answer in rd as {err, rdata}
  task automatic fb_xfer(input logic p, input logic [7:0] s, input logic w,
                         input logic [7:0] r, input logic [15:0] d);
    @(posedge clock);
    fb_req <= {1'h1, p, s, w, r, d};
    @(negedge clock);
    while (fb_ready !== 1'h1) begin
      @(negedge clock);
    end
    @(posedge clock);
    fb_req.valid <= 1'h0;
    @(negedge clock);
    while (fb_rsp.valid !== 1'h1) begin
      @(negedge clock);
    end
    rd = {15'h0, fb_rsp.err, fb_rsp.rdata};
  endtask

  // Wait for a card word, bounded, then compare
  task automatic wait_card(input int s, input int w, input logic [15:0] e);
    int n;
    n = 0;
    while (card.mem[s][w] !== e && n < 800) begin
      @(posedge clock);
      n++;
    end
    chk("card word", {16'h0, card.mem[s][w]}, {16'h0, e});
  endtask

  // Reset values of setup outputs and registers
  task automatic t_defaults();
    chk("ser_cfg", ser_cfg, SER_RST);
    chk("dual_slave", dual_slave, 1'h1);
    av_xfer(1'h0, OFF_SER, 32'h0);
    chk("serial reg", rd, SER_RST);
    av_xfer(1'h0, OFF_CTRL, 32'h0);
    chk("ctrl reg", rd, CTRL_RST);
    av_xfer(1'h0, OFF_TMO, 32'h0);
    chk("timeout reg", rd, TMO_RST);
    av_xfer(1'h0, 8'hfc, 32'h0);
    chk("unmapped reg", rd, 32'h0);
  endtask

  // Slave addresses, protocols and dual slave mode
  task automatic t_slaves();
    fb_xfer(PROTO_MODBUS, SLV_CFG, 1'h1, 8'h01, 16'h0064);
    chk("cfg write err", rd[16], 1'h0);
    av_xfer(1'h0, OFF_TMO, 32'h0);
    chk("timeout via cfg", rd, 32'h00000064);
    fb_xfer(PROTO_MODBUS, 8'h07, 1'h0, 8'h01, 16'h0);
    chk("bad slave err", rd[16], 1'h1);
    fb_xfer(PROTO_MODBUS, SLV_RACK_A, 1'h0, 8'h01, 16'h0);
    chk("slave 0 err", rd[16], 1'h0);
    fb_xfer(PROTO_NATIVE, SLV_RACK_B, 1'h0, 8'h01, 16'h0);
    chk("native err", rd[16], 1'h0);
    av_xfer(1'h1, OFF_CTRL, 32'h00000002);
    fb_xfer(PROTO_NATIVE, SLV_RACK_B, 1'h0, 8'h01, 16'h0);
    chk("native single err", rd[16], 1'h1);
    av_xfer(1'h1, OFF_CTRL, CTRL_RST);
    av_xfer(1'h0, OFF_ERR, 32'h0);
    chk("error count", rd, 32'h00000002);
  endtask

  // Rack input and output entries, mapper copies with reversal
  task automatic t_rack();
    // Seed the words that output entries read, so no unknown leaves the block
    fb_xfer(PROTO_MODBUS, SLV_RACK_B, 1'h1, 8'hdc, 16'h0003);
    fb_xfer(PROTO_MODBUS, SLV_RACK_B, 1'h1, 8'h04, 16'h0000);
    fb_xfer(PROTO_MODBUS, SLV_RACK_B, 1'h1, 8'h05, 16'h1234);
    av_xfer(1'h1, OFF_RACK, {3'h0, 1'h0, 8'h01, 8'h01, 4'h2, 8'h64});
    av_xfer(1'h1, OFF_RACK + 8'h04, {3'h0, 1'h1, 8'h02, 8'h01, 4'h3, 8'h04});
    av_xfer(1'h1, OFF_RDEF + 8'h04, 32'h000000a5);
    av_xfer(1'h1, OFF_MAP, {8'h01, 8'h64, SRC_RACK, 8'hc8});
    av_xfer(1'h1, OFF_MCTL, 32'h00020000);
    // Control first, so the entry never runs as an input copy over the target
    av_xfer(1'h1, OFF_MCTL + 8'h04, 32'h00030f0f);
    av_xfer(1'h1, OFF_MAP + 8'h04, {8'h01, 8'h04, SRC_RACK, 8'hdc});
    wait_card(3, 2, 16'h1234);
    wait_card(3, 1, rev16(16'h0003));
    fb_xfer(PROTO_MODBUS, SLV_RACK_A, 1'h0, 8'h64, 16'h0);
    chk("input word", rd, {16'h0, 4'h2, 8'h01, 4'ha});
    fb_xfer(PROTO_MODBUS, SLV_RACK_A, 1'h0, 8'hc8, 16'h0);
    chk("reversed input", rd, {16'h0, rev16({4'h2, 8'h01, 4'ha})});
    av_xfer(1'h1, OFF_MAP, {8'h01, 8'h02, SRC_INT, 8'hd2});
    av_xfer(1'h1, OFF_MCTL, 32'h0);
    repeat (20) begin
      fb_xfer(PROTO_MODBUS, SLV_RACK_A, 1'h0, 8'hd2, 16'h0);
    end
    chk("internal source", rd, {16'h0, SER_BAUD});
  endtask

  // Timeout defaults with slow cards, then recovery on a message
  task automatic t_timeout();
    int n;
    slow <= 1'h1;
    fb_xfer(PROTO_MODBUS, SLV_RACK_B, 1'h0, 8'h05, 16'h0);
    repeat (380) @(posedge clock);
    chk("early timeout", timed_out, 1'h0);
    n = 0;
    while (timed_out !== 1'h1 && n < 60) begin
      @(posedge clock);
      n++;
    end
    chk("timed out", timed_out, 1'h1);
    av_xfer(1'h0, OFF_STAT, 32'h0);
    chk("status flag", rd[0], 1'h1);
    wait_card(3, 2, 16'h00a5);
    wait_card(3, 1, 16'h0f0f);
    fb_xfer(PROTO_MODBUS, SLV_RACK_B, 1'h1, 8'h05, 16'h5678);
    @(posedge clock);
    chk("timeout cleared", timed_out, 1'h0);
    wait_card(3, 2, 16'h5678);
    // Scan off: no step runs, card keeps its word until scan resumes
    av_xfer(1'h1, OFF_CTRL, 32'h00000001);
    fb_xfer(PROTO_MODBUS, SLV_RACK_B, 1'h1, 8'h05, 16'h9abc);
    repeat (40) @(posedge clock);
    av_xfer(1'h0, OFF_STAT, 32'h0);
    chk("busy with scan off", rd[1], 1'h0);
    chk("card word with scan off", {16'h0, card.mem[3][2]}, 32'h00005678);
    av_xfer(1'h1, OFF_CTRL, CTRL_RST);
    wait_card(3, 2, 16'h9abc);
  endtask

  // Watchdog ends a hung run
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    t_defaults();
    t_slaves();
    t_rack();
    t_timeout();
    close_out();
  end
endmodule // tb
